// file: hw/lsc_defines.svh
// Shared constants of the link supervisor: register offsets, bit fields,
// error codes and default timer figures.
// Assumes inclusion by bare name from files under hw/.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// Register offsets
`define LSC_REG_CTRL 4'h0
`define LSC_REG_STATUS 4'h1
`define LSC_REG_INDEX_A 4'h2
`define LSC_REG_INDEX_B 4'h3
`define LSC_REG_ERROR 4'h4
`define LSC_REG_TX_RDY 4'h5
`define LSC_REG_RX_RDY 4'h6
`define LSC_REG_TX_TX_FLAG_A 4'h7
`define LSC_REG_RX_CPL 4'h8

// Control bits
`define LSC_CTRL_MANUAL_DISCONNECT 0
`define LSC_CTRL_RX_EN 1
`define LSC_CTRL_TX_GO 2
`define LSC_CTRL_DECOUPLE 3
`define LSC_CTRL_RESET 8'h01

// Error codes
`define LSC_ERR_NONE 8'h00
`define LSC_ERR_FRMR_RX 8'hC0
`define LSC_ERR_BAD_NR 8'hC8
`define LSC_ERR_RX_NOT_READY 8'h10
`define LSC_ERR_UP_READY 8'h21
`define LSC_ERR_UP_BUSY 8'h11

// Pending frame slots, highest priority first
`define LSC_P_UA 0
`define LSC_P_SABM 1
`define LSC_P_FRMR 2
`define LSC_P_RSP 3
`define LSC_P_SCMD 4
`define LSC_P_IFRM 5

// T1 in link bit times, N2 in tries
`define LSC_T1_TICKS 1000
`define LSC_N2_DEFAULT 10

`endif

// file: hw/lsc_pkg.sv
// Types of the link supervisor: frame kinds and state machine codes.
// Assumes nothing of its surroundings.
package lsc_pkg;

  typedef enum logic [3:0] {
    FR_I = 4'h0,
    FR_RR = 4'h1,
    FR_RNR = 4'h2,
    FR_REJ = 4'h3,
    FR_SABM = 4'h4,
    FR_DISC = 4'h5,
    FR_UA = 4'h6,
    FR_FRMR = 4'h7,
    FR_DM = 4'h8
  } lsc_frame_t;

  typedef enum logic [2:0] {
    LK_DOWN = 3'b001,
    LK_SETUP = 3'b010,
    LK_UP = 3'b100
  } lsc_link_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_WAIT = 2'b10
  } lsc_txst_t;

endpackage

// file: hw/lsc_desc_flags.sv
// Descriptor flag store: buffer-ready, acknowledged and frame-complete
// bits of the transmit and receive descriptor tables.
// Assumes one clock; host writes come from the register decoder.
`timescale 1ns/100ps
module lsc_desc_flags #(
  parameter int IW = 3,
  parameter int DEPTH = 8
) (
  // Clock
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Host side
  input wire logic wr_tx_rdy,
  input wire logic wr_rx_rdy,
  input wire logic clr_tx_flag_a,
  input wire logic clr_cpl,
  input wire logic [DEPTH-1:0] host_data,
  // Device side
  input wire logic ack_set,
  input wire logic [IW-1:0] ack_lo,
  input wire logic [IW-1:0] ack_hi,
  input wire logic cpl_set,
  input wire logic [IW-1:0] cpl_idx,
  // Flag vectors
  output logic [DEPTH-1:0] tx_rdy,
  output logic [DEPTH-1:0] rx_rdy,
  output logic [DEPTH-1:0] tx_flag_a,
  output logic [DEPTH-1:0] cpl
);

  generate
    if (DEPTH != (1 << IW)) begin : g_bad
      $error("lsc_desc_flags: DEPTH must be 2**IW");
    end
  endgenerate

  logic [DEPTH-1:0] ack_mask;
  logic [DEPTH-1:0] cpl_mask;

  // Circular range lo .. hi-1
  always_comb begin
    ack_mask = '0;
    cpl_mask = '0;
    for (int i = 0; i < DEPTH; i++) begin
      ack_mask[i] = (IW'(IW'(i) - ack_lo) < IW'(ack_hi - ack_lo)) & ack_set;
      cpl_mask[i] = cpl_set & (IW'(i) == cpl_idx);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_rdy <= '0;
      rx_rdy <= '0;
    end else if (ce) begin
      if (wr_tx_rdy) begin
        tx_rdy <= host_data;
      end
      if (wr_rx_rdy) begin
        rx_rdy <= host_data;
      end
    end
  end

  // Set wins over a host clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_flag_a <= '0;
      cpl <= '0;
    end else if (ce) begin
      tx_flag_a <= (tx_flag_a & ~(clr_tx_flag_a ? host_data : '0)) | ack_mask;
      cpl <= (cpl & ~(clr_cpl ? host_data : '0)) | cpl_mask;
    end
  end

endmodule

// file: hw/lsc_supervisor.sv
// Link supervisor: S-command choice, T1/N2 polling, link reset, frame
// reject handling, receiver-ready handshake and index upkeep.
// Assumes a frame decoder and encoder on clk; link_clk is a raw pin.
`timescale 1ns/100ps
`include "lsc_defines.svh"

// Overview of operation
// - S-command is RR, RNR when busy, REJ pending
// - Every S-command carries poll bit one
// - Repeat S-command each T1 while busy/unacked
// - SABM on FRMR or N2 unanswered polls
// - Unsolicited UA or F sends FRMR W
// - FRMR sent only while link up
// - After FRMR: no packets, discard I-fields
// - Reject condition still accepts acknowledgements
// - SABM/DISC answer UA, leave reject condition
// - Resend FRMR, or new FRMR on errors
// - FRMR received: store field, stop, hold receiver
// - FRMR received: send SABM, error C0
// - UA after reset SABM zeroes all indexes
// - Indexes track sequence state variables
// - Sample receiver enable at release and resets
// - Busy clears after enable, ready, frame
// - Next descriptor not ready sets busy, code 10
// - Descriptor zero usable right after reset; here tx_rdy/rx_rdy reset to zero until the host writes them
// - Link reset clears transmit-go
// - N(R) valid from oldest through next index
module lsc_supervisor
  import lsc_pkg::*;
#(
  parameter int T1_TICKS = `LSC_T1_TICKS,
  parameter int N2_MAX = `LSC_N2_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Link bit clock pin
  input wire logic link_clk,
  // Received frame from decoder
  input wire logic rx_valid,
  input wire lsc_frame_t rx_kind,
  input wire logic rx_is_cmd,
  input wire logic rx_pf,
  input wire logic [2:0] rx_nr,
  input wire logic [2:0] rx_ns,
  input wire logic [2:0] rx_viol,
  output logic rx_store,
  output logic [2:0] rx_store_idx,
  // Frame request to encoder
  output logic tx_req,
  output lsc_frame_t tx_kind,
  output logic tx_is_cmd,
  output logic tx_pf,
  output logic [2:0] tx_nr,
  output logic [2:0] tx_ns,
  output logic [3:0] tx_frmr_wxyz,
  input wire logic tx_ack,
  // Event pulses
  output logic tx_ack_irq,
  output logic rx_not_ready_irq,
  output logic err_irq
);

  generate
    if (T1_TICKS < 2 || T1_TICKS > 65535 || N2_MAX < 1 || N2_MAX > 15)
    begin : g_bad
      $error("lsc_supervisor: T1_TICKS or N2_MAX out of range");
    end
  endgenerate

  lsc_link_t link_ff;
  lsc_txst_t txst_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] error_code_reg_ff;
  logic [2:0] oldest_unacked_index_ff, next_tx_index_ff, next_rx_index_ff;
  logic [2:0] vs_ff, vr_ff;
  logic [5:0] pend_ff;
  logic local_busy_sent_ff, remote_busy_flag_ff, frmr_cond_ff, rx_hold_ff;
  logic rej_cond_ff, rej_pend_ff, rsp_f_ff, poll_out_ff;
  logic need_sample_ff, busy_arm_ff, md_prev_ff;
  logic [3:0] frmr_code_ff;
  logic [15:0] t1_cnt_ff;
  logic [3:0] n2_cnt_ff;
  logic lk_s1_ff, lk_s2_ff, lk_s3_ff;
  logic [7:0] tx_rdy, rx_rdy, tx_flag_a, cpl;

  // Short names for control bits and link-up
  logic md, rx_en, decouple, up;
  assign md = ctrl_ff[`LSC_CTRL_MANUAL_DISCONNECT];
  assign rx_en = ctrl_ff[`LSC_CTRL_RX_EN];
  assign decouple = ctrl_ff[`LSC_CTRL_DECOUPLE];
  assign up = (link_ff == LK_UP);

  // Link clock pin: two flops, then edge detect on the second
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_s1_ff <= 1'b0;
      lk_s2_ff <= 1'b0;
      lk_s3_ff <= 1'b0;
    end else if (ce) begin
      lk_s1_ff <= link_clk;
      lk_s2_ff <= lk_s1_ff;
      lk_s3_ff <= lk_s2_ff;
    end
  end

  logic tick;
  assign tick = lk_s2_ff & ~lk_s3_ff;

  // Receive decode
  logic ev, is_i, is_s, nr_ok, ev_sabm, ev_disc, ev_frmr, ev_ua_reset;
  logic ev_unsol, ev_ack, ev_f_ok, ev_in_seq, ev_accept, ev_reset_done;
  logic [2:0] d_nr, d_nb, d_vs;
  always_comb begin
    ev = ce & rx_valid & ~md;
    is_i = (rx_kind == FR_I);
    is_s = (rx_kind == FR_RR) | (rx_kind == FR_RNR) | (rx_kind == FR_REJ);
    d_nr = rx_nr - oldest_unacked_index_ff;
    d_nb = next_tx_index_ff - oldest_unacked_index_ff;
    d_vs = vs_ff - oldest_unacked_index_ff;
    nr_ok = (d_nr <= d_nb);
    ev_sabm = ev & (rx_kind == FR_SABM);
    ev_disc = ev & (rx_kind == FR_DISC);
    ev_frmr = ev & up & (rx_kind == FR_FRMR);
    ev_ua_reset = ev & (rx_kind == FR_UA) & (link_ff == LK_SETUP);
    ev_unsol = ev & up & ((rx_kind == FR_UA)
               | (~rx_is_cmd & rx_pf & ~poll_out_ff & (is_i | is_s)));
    ev_ack = ev & up & (is_i | is_s) & nr_ok & (d_nr != 3'h0);
    ev_f_ok = ev & up & is_s & ~rx_is_cmd & rx_pf & poll_out_ff;
    ev_in_seq = ev & up & is_i & (rx_ns == vr_ff) & nr_ok;
    ev_accept = ev_in_seq & ~local_busy_sent_ff & ~frmr_cond_ff
                & ~rx_hold_ff;
    ev_reset_done = ev_ua_reset | ev_sabm;
  end

  // T1 timer on link bit times
  logic t1_run, t1_exp, n2_out;
  assign t1_run = (link_ff == LK_SETUP) | (up & (remote_busy_flag_ff
                  | (d_nb != 3'h0) | poll_out_ff));
  assign t1_exp = ce & t1_run & tick & (t1_cnt_ff == 16'(T1_TICKS - 1));
  assign n2_out = (n2_cnt_ff >= 4'(N2_MAX));

  always_ff @(posedge clk) begin
    if (rst) begin
      t1_cnt_ff <= 16'h0000;
    end else if (ce) begin
      if (~t1_run | ev_ack | ev_f_ok | t1_exp) begin
        t1_cnt_ff <= 16'h0000;
      end else if (tick) begin
        t1_cnt_ff <= t1_cnt_ff + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      n2_cnt_ff <= 4'h0;
    end else if (ce) begin
      if (ev_ack | ev_f_ok | ev_reset_done | ~t1_run) begin
        n2_cnt_ff <= 4'h0;
      end else if (t1_exp) begin
        n2_cnt_ff <= n2_out ? 4'h0 : n2_cnt_ff + 4'h1;
      end
    end
  end

  // Transmit choice
  logic send_ok;
  logic [5:0] cand, pick;
  lsc_frame_t s_kind;
  always_comb begin
    send_ok = up & ~frmr_cond_ff & ctrl_ff[`LSC_CTRL_TX_GO]
              & tx_rdy[vs_ff] & ~remote_busy_flag_ff
              & ~((vs_ff == next_tx_index_ff)
                  & (3'(next_tx_index_ff + 3'h1) == oldest_unacked_index_ff));
    cand = pend_ff & {1'b0, {3{up}}, ~md, 1'b1};
    cand[`LSC_P_IFRM] = send_ok;
    pick = (txst_ff == TX_IDLE) ? (cand & 6'(~cand + 6'h01)) : 6'h00;
    if (local_busy_sent_ff) begin
      s_kind = FR_RNR;
    end else if (rej_pend_ff) begin
      s_kind = FR_REJ;
    end else begin
      s_kind = FR_RR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txst_ff <= TX_IDLE;
      tx_kind <= FR_RR;
      tx_is_cmd <= 1'b0;
      tx_pf <= 1'b0;
      tx_nr <= 3'h0;
      tx_ns <= 3'h0;
      tx_frmr_wxyz <= 4'h0;
    end else if (ce) begin
      case (txst_ff)
        TX_IDLE: begin
          if (pick != 6'h00) begin
            txst_ff <= TX_WAIT;
            tx_nr <= vr_ff;
            tx_ns <= vs_ff;
            tx_frmr_wxyz <= frmr_code_ff;
            tx_is_cmd <= pick[`LSC_P_SABM] | pick[`LSC_P_SCMD]
                         | pick[`LSC_P_IFRM];
            tx_pf <= pick[`LSC_P_UA] | pick[`LSC_P_SABM]
                     | pick[`LSC_P_SCMD] | (pick[`LSC_P_RSP] & rsp_f_ff);
            if (pick[`LSC_P_UA]) begin
              tx_kind <= FR_UA;
            end else if (pick[`LSC_P_SABM]) begin
              tx_kind <= FR_SABM;
            end else if (pick[`LSC_P_FRMR]) begin
              tx_kind <= FR_FRMR;
            end else if (pick[`LSC_P_IFRM]) begin
              tx_kind <= FR_I;
            end else begin
              tx_kind <= s_kind;
            end
          end
        end
        TX_WAIT: begin
          if (tx_ack) begin
            txst_ff <= TX_IDLE;
          end
        end
        default: txst_ff <= TX_IDLE;
      endcase
    end
  end

  assign tx_req = (txst_ff == TX_WAIT);

  // Pending frames: a new cause wins over the pick that clears it
  logic [5:0] pend_set;
  logic frmr_new;
  always_comb begin
    frmr_new = ev_unsol | (ev & up & (is_i | is_s) & ~nr_ok)
               | (ev & up & (rx_viol != 3'h0));
    pend_set = 6'h00;
    pend_set[`LSC_P_UA] = ev_sabm | ev_disc;
    pend_set[`LSC_P_SABM] = ev_frmr | (t1_exp & n2_out & up)
                            | (t1_exp & (link_ff == LK_SETUP))
                            | (ce & md_prev_ff & ~md);
    pend_set[`LSC_P_FRMR] = frmr_new
                            | (frmr_cond_ff & ev & (is_i | is_s));
    pend_set[`LSC_P_RSP] = (ev & up & (is_i | is_s) & rx_is_cmd & rx_pf)
                           | ev_accept | (ev_in_seq & local_busy_sent_ff)
                           | (ev & up & is_i & ~ev_in_seq)
                           | (need_sample_ff & up & ce);
    pend_set[`LSC_P_SCMD] = t1_exp & up & ~n2_out;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff <= 6'h00;
      rsp_f_ff <= 1'b0;
    end else if (ce) begin
      pend_ff <= (pend_ff & ~pick & {6{~md}}) | pend_set;
      if (pend_set[`LSC_P_RSP]) begin
        rsp_f_ff <= rx_is_cmd & rx_pf & ev;
      end
    end
  end

  // Link state and reject condition
  always_ff @(posedge clk) begin
    if (rst) begin
      link_ff <= LK_DOWN;
      md_prev_ff <= 1'b1;
      frmr_cond_ff <= 1'b0;
      frmr_code_ff <= 4'h0;
      poll_out_ff <= 1'b0;
    end else if (ce) begin
      md_prev_ff <= md;
      if (pick[`LSC_P_SCMD]) begin
        poll_out_ff <= 1'b1;
      end else if (ev_f_ok | ~up) begin
        poll_out_ff <= 1'b0;
      end
      if (frmr_new) begin
        frmr_code_ff <= {(is_i | is_s) & ~nr_ok & ~ev_unsol,
                         rx_viol[2:1], rx_viol[0] | ev_unsol};
      end
      if (pick[`LSC_P_FRMR]) begin
        frmr_cond_ff <= 1'b1;
      end else if (ev_sabm | ev_disc | ~up) begin
        frmr_cond_ff <= 1'b0;
      end
      if (md) begin
        link_ff <= LK_DOWN;
      end else begin
        case (link_ff)
          LK_DOWN: begin
            if (md_prev_ff | ev_sabm) begin
              link_ff <= ev_sabm ? LK_UP : LK_SETUP;
            end
          end
          LK_SETUP: begin
            if (ev_ua_reset | ev_sabm) begin
              link_ff <= LK_UP;
            end
          end
          LK_UP: begin
            if (ev_disc) begin
              link_ff <= LK_DOWN;
            end else if (ev_frmr | pick[`LSC_P_SABM]) begin
              link_ff <= LK_SETUP;
            end
          end
          default: link_ff <= LK_DOWN;
        endcase
      end
    end
  end

  // Sequence state and table indexes
  always_ff @(posedge clk) begin
    if (rst) begin
      oldest_unacked_index_ff <= 3'h0;
      next_tx_index_ff <= 3'h0;
      next_rx_index_ff <= 3'h0;
      vs_ff <= 3'h0;
      vr_ff <= 3'h0;
    end else if (ce) begin
      if (ev_reset_done) begin
        oldest_unacked_index_ff <= 3'h0;
        next_tx_index_ff <= 3'h0;
        next_rx_index_ff <= 3'h0;
        vs_ff <= 3'h0;
        vr_ff <= 3'h0;
      end else begin
        if (ev_ack) begin
          oldest_unacked_index_ff <= rx_nr;
        end
        if (ev & up & nr_ok & ~frmr_cond_ff & ((rx_kind == FR_REJ)
            | (d_nr > d_vs))) begin
          vs_ff <= rx_nr;
        end else if (pick[`LSC_P_IFRM]) begin
          vs_ff <= vs_ff + 3'h1;
          if (vs_ff == next_tx_index_ff) begin
            next_tx_index_ff <= next_tx_index_ff + 3'h1;
          end
        end
        if (ev_accept) begin
          vr_ff <= vr_ff + 3'h1;
          next_rx_index_ff <= next_rx_index_ff + 3'h1;
        end else if (~decouple) begin
          next_rx_index_ff <= vr_ff;
        end
      end
    end
  end

  // Remote busy and reject condition
  always_ff @(posedge clk) begin
    if (rst) begin
      remote_busy_flag_ff <= 1'b0;
      rej_cond_ff <= 1'b0;
      rej_pend_ff <= 1'b0;
    end else if (ce) begin
      if (ev & (rx_kind == FR_RNR)) begin
        remote_busy_flag_ff <= 1'b1;
      end else if (ev & ((rx_kind == FR_RR) | (rx_kind == FR_REJ)
                   | (rx_kind == FR_UA)) | ~up) begin
        remote_busy_flag_ff <= 1'b0;
      end
      if (ev_reset_done | ev_in_seq) begin
        rej_cond_ff <= 1'b0;
        rej_pend_ff <= 1'b0;
      end else if (ev & up & is_i & ~rej_cond_ff & ~local_busy_sent_ff
                   & (3'(rx_ns + 3'h1) != vr_ff)) begin
        rej_cond_ff <= 1'b1;
        rej_pend_ff <= 1'b1;
      end else if (pick[`LSC_P_RSP] & ~local_busy_sent_ff) begin
        rej_pend_ff <= 1'b0;
      end
    end
  end

  // Receiver-ready handshake
  logic rdy_next, busy_set;
  assign rdy_next = rx_en & rx_rdy[next_rx_index_ff];
  assign busy_set = ce & up & ((need_sample_ff & ~rdy_next)
                    | (ev_accept & ~rx_rdy[3'(next_rx_index_ff + 3'h1)]));

  always_ff @(posedge clk) begin
    if (rst) begin
      need_sample_ff <= 1'b0;
      busy_arm_ff <= 1'b0;
      local_busy_sent_ff <= 1'b0;
      rx_hold_ff <= 1'b0;
    end else if (ce) begin
      if ((md_prev_ff & ~md) | ev_reset_done) begin
        need_sample_ff <= 1'b1;
      end else if (up) begin
        need_sample_ff <= 1'b0;
      end
      busy_arm_ff <= local_busy_sent_ff & (busy_arm_ff | rdy_next);
      if (busy_set) begin
        local_busy_sent_ff <= 1'b1;
      end else if (ev_reset_done
                   | (ev & up & (is_i | is_s) & busy_arm_ff)) begin
        local_busy_sent_ff <= 1'b0;
      end
      if (ev_frmr) begin
        rx_hold_ff <= 1'b1;
      end else if (reg_wr & (reg_addr == `LSC_REG_RX_RDY)) begin
        rx_hold_ff <= 1'b0;
      end
    end
  end

  // I-field storage; a received FRMR lands in the current segment
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_store <= 1'b0;
      rx_store_idx <= 3'h0;
    end else if (ce) begin
      rx_store <= ev_accept | (ev_frmr & ~local_busy_sent_ff
                  & ~rx_hold_ff);
      rx_store_idx <= next_rx_index_ff;
    end
  end

  // Event pulses and error code
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ack_irq <= 1'b0;
      rx_not_ready_irq <= 1'b0;
      err_irq <= 1'b0;
      error_code_reg_ff <= `LSC_ERR_NONE;
    end else if (ce) begin
      tx_ack_irq <= ev_ack;
      rx_not_ready_irq <= busy_set & rx_en;
      err_irq <= ev_frmr | (ev & up & (is_i | is_s) & ~nr_ok)
                 | (busy_set & rx_en) | ev_ua_reset;
      if (ev_frmr) begin
        error_code_reg_ff <= `LSC_ERR_FRMR_RX;
      end else if (ev & up & (is_i | is_s) & ~nr_ok) begin
        error_code_reg_ff <= `LSC_ERR_BAD_NR;
      end else if (ev_ua_reset) begin
        error_code_reg_ff <= rdy_next ? `LSC_ERR_UP_READY
                                      : `LSC_ERR_UP_BUSY;
      end else if (busy_set & rx_en) begin
        error_code_reg_ff <= `LSC_ERR_RX_NOT_READY;
      end
    end
  end

  // Control register; a link reset drops transmit-go even over a write
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= `LSC_CTRL_RESET;
    end else if (ce) begin
      if (reg_wr & (reg_addr == `LSC_REG_CTRL)) begin
        ctrl_ff <= {4'h0, reg_wdata[3:0]};
      end
      if (ev_frmr | ev_reset_done) begin
        ctrl_ff[`LSC_CTRL_TX_GO] <= 1'b0;
      end
    end
  end

  lsc_desc_flags #(
    .IW(3),
    .DEPTH(8)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wr_tx_rdy(reg_wr & (reg_addr == `LSC_REG_TX_RDY)),
    .wr_rx_rdy(reg_wr & (reg_addr == `LSC_REG_RX_RDY)),
    .clr_tx_flag_a(reg_wr & (reg_addr == `LSC_REG_TX_TX_FLAG_A)),
    .clr_cpl(reg_wr & (reg_addr == `LSC_REG_RX_CPL)),
    .host_data(reg_wdata),
    .ack_set(ev_ack),
    .ack_lo(oldest_unacked_index_ff),
    .ack_hi(rx_nr),
    .cpl_set(ce & (ev_accept | (ev_frmr & ~local_busy_sent_ff
             & ~rx_hold_ff))),
    .cpl_idx(next_rx_index_ff),
    .tx_rdy(tx_rdy),
    .rx_rdy(rx_rdy),
    .tx_flag_a(tx_flag_a),
    .cpl(cpl)
  );

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `LSC_REG_CTRL: reg_rdata <= ctrl_ff;
          `LSC_REG_STATUS: reg_rdata <= {2'b00, rx_hold_ff, rej_cond_ff,
            frmr_cond_ff, remote_busy_flag_ff, local_busy_sent_ff, up};
          `LSC_REG_INDEX_A: reg_rdata <= {1'b0, next_tx_index_ff, 1'b0,
            oldest_unacked_index_ff};
          `LSC_REG_INDEX_B: reg_rdata <= {1'b0, vr_ff, 1'b0,
            next_rx_index_ff};
          `LSC_REG_ERROR: reg_rdata <= error_code_reg_ff;
          `LSC_REG_TX_RDY: reg_rdata <= tx_rdy;
          `LSC_REG_RX_RDY: reg_rdata <= rx_rdy;
          `LSC_REG_TX_TX_FLAG_A: reg_rdata <= tx_flag_a;
          `LSC_REG_RX_CPL: reg_rdata <= cpl;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: testbench/lsc_supervisor_props.sv
// Checker of frame requests and read-data timing.
// Assumes a bind to lsc_supervisor; sees its ports only.
`timescale 1ns/100ps
module lsc_sup_props
  import lsc_pkg::*;
#(
  parameter int T1_TICKS = 4,
  parameter int N2_MAX = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register read
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Frames
  input wire logic rx_valid,
  input wire lsc_frame_t rx_kind,
  input wire logic rx_store,
  input wire logic tx_req,
  input wire lsc_frame_t tx_kind,
  input wire logic tx_is_cmd,
  input wire logic tx_pf,
  input wire logic tx_ack,
  input wire logic tx_ack_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_SCMD_POLL: assert property (
    tx_req && tx_is_cmd && tx_kind inside {FR_RR, FR_RNR, FR_REJ}
    |-> tx_pf) else $error("no poll bit");
  AST_SABM_CMD: assert property (
    tx_req && tx_kind == FR_SABM |-> tx_is_cmd && tx_pf)
    else $error("bad SABM");
  AST_UA_FINAL: assert property (
    tx_req && tx_kind == FR_UA |-> !tx_is_cmd && tx_pf)
    else $error("bad UA");
  AST_REQ_HOLD: assert property (
    tx_req && !tx_ack |=> tx_req && $stable({tx_kind, tx_pf}))
    else $error("request moved");
  AST_REQ_DROP: assert property (tx_req && tx_ack |=> !tx_req)
    else $error("request kept");
  AST_RD_IDLE: assert property (reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data kept");
  AST_STORE_SRC: assert property (
    rx_store |-> $past(rx_valid) && $past(rx_kind) inside {FR_I, FR_FRMR})
    else $error("store without field");
  AST_ACK_SRC: assert property (tx_ack_irq |-> $past(rx_valid))
    else $error("ack without frame");
  COV_SABM: cover property (tx_req && tx_ack && tx_kind == FR_SABM);
  COV_UA: cover property (tx_req && tx_ack && tx_kind == FR_UA);
  COV_POLL: cover property (tx_ack && tx_kind == FR_RR && tx_is_cmd);
endmodule

bind lsc_supervisor lsc_sup_props #(.T1_TICKS(T1_TICKS), .N2_MAX(N2_MAX))
  u_props (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_store(rx_store),
  .tx_req(tx_req), .tx_kind(tx_kind), .tx_is_cmd(tx_is_cmd),
  .tx_pf(tx_pf), .tx_ack(tx_ack), .tx_ack_irq(tx_ack_irq));

// file: testbench/lsc_peer_model.sv
// Frame encoder stand-in: takes requests promptly or slowly.
// Assumes a request stays up until acknowledged.
`timescale 1ns/100ps
module lsc_peer_model (
  // Clock
  input wire logic clk,
  input wire logic rst,
  // Handshake
  input wire logic slow,
  input wire logic tx_req,
  output logic tx_ack
);
  logic [1:0] wait_ff;
  always_ff @(posedge clk) begin
    if (rst || !tx_req || tx_ack) begin
      wait_ff <= 2'h0;
      tx_ack <= 1'b0;
    end else if (!slow || wait_ff == 2'h3) begin
      tx_ack <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

// file: testbench/lsc_supervisor_tb_top.sv
// Bench of the link supervisor: set-up, reject, reset and polling.
// Assumes lsc_peer_model as encoder and the bound checker.
`timescale 1ns/100ps
module lsc_supervisor_tb_top
  import lsc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, link_clk = 1'b0, slow = 1'b0, ce = 1'b1;
  logic tx_ack_irq, rx_not_ready_irq, err_irq;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rx_valid = 1'b0, rx_is_cmd = 1'b0;
  logic rx_pf = 1'b0, rd_d = 1'b0, tx_req, tx_pf, tx_is_cmd, tx_ack;
  logic [3:0] reg_addr = 4'h0, tx_frmr_wxyz;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, irq_cnt = 8'h00;
  logic [2:0] rx_ns = 3'h0, rx_nr = 3'h0;
  logic [16:0] seed = 17'h13634;
  lsc_frame_t rx_kind = FR_RR, tx_kind;
  logic [7:0] tq[$], rq[$];
  int error_cnt = 0, num_checks = 0;

  always #10 clk = ~clk;
  // Offset keeps link edges off the system clock edges
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end

  lsc_supervisor #(.T1_TICKS(4), .N2_MAX(2)) uut (.clk(clk), .rst(rst),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .rx_valid(rx_valid), .rx_kind(rx_kind), .rx_is_cmd(rx_is_cmd),
    .rx_pf(rx_pf), .rx_nr(rx_nr), .rx_ns(rx_ns), .rx_viol(3'h0),
    .rx_store(), .rx_store_idx(), .tx_req(tx_req), .tx_kind(tx_kind),
    .tx_is_cmd(tx_is_cmd), .tx_pf(tx_pf), .tx_nr(), .tx_ns(),
    .tx_frmr_wxyz(tx_frmr_wxyz), .tx_ack(tx_ack), .tx_ack_irq(tx_ack_irq),
    .rx_not_ready_irq(rx_not_ready_irq), .err_irq(err_irq));
  lsc_peer_model peer (.clk(clk), .rst(rst), .slow(slow), .tx_req(tx_req),
    .tx_ack(tx_ack));

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  // Received frame; N(R) stays valid for the scenarios below
  task automatic frame(input lsc_frame_t k, input logic c, input logic pf);
    seed = lfsr(seed);
    rx_kind <= k;
    rx_is_cmd <= c;
    rx_pf <= pf;
    rx_ns <= seed[2:0];
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain();
    int n;
    n = 1000;
    while (tq.size() != 0 && n > 0) begin
      @(posedge clk);
      n--;
    end
    if (n == 0) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // FRMR compared by its reason bits, others by command and poll bits
  always @(posedge clk) begin
    rd_d <= reg_rd;
    // Pulse counts: bit 7 not-ready, bit 4 error, bit 0 acknowledge
    irq_cnt <= irq_cnt + {rx_not_ready_irq, 2'h0, err_irq, 3'h0, tx_ack_irq};
    if (rd_d) chk(reg_rdata, rq.size() ? rq.pop_front() : 8'hFF);
    if (tx_req && tx_ack)
      chk(tx_kind == FR_FRMR ? {tx_frmr_wxyz, tx_kind} :
        {tx_pf, tx_is_cmd, 2'h0, tx_kind},
        tq.size() ? tq.pop_front() : 8'hFF);
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h01);
    wr(4'h6, 8'hFF);
    tq.push_back(8'hC4);
    wr(4'h0, 8'h06);
    drain();
    tq.push_back(8'h01);
    frame(FR_UA, 1'b0, 1'b1);
    rd(4'h4, 8'h21);
    rd(4'h2, 8'h00);
    tq.push_back(8'h17);
    frame(FR_RR, 1'b0, 1'b1);
    drain();
    tq.push_back(8'h17);
    frame(FR_RR, 1'b0, 1'b0);
    drain();
    tq.push_back(8'h86);
    tq.push_back(8'h01);
    frame(FR_SABM, 1'b1, 1'b1);
    drain();
    rd(4'h0, 8'h02);
    ce <= 1'b0;
    wr(4'h0, 8'h07);
    ce <= 1'b1;
    rd(4'h0, 8'h02);
    tq.push_back(8'hC4);
    frame(FR_FRMR, 1'b0, 1'b0);
    drain();
    rd(4'h4, 8'hC0);
    tq.push_back(8'h01);
    frame(FR_UA, 1'b0, 1'b1);
    rd(4'h2, 8'h00);
    rd(4'h8, 8'h01);
    wr(4'h5, 8'h01);
    tq.push_back(8'h40);
    wr(4'h0, 8'h06);
    drain();
    rx_nr <= 3'h1;
    frame(FR_RR, 1'b0, 1'b0);
    rd(4'h2, 8'h11);
    rd(4'h7, 8'h01);
    slow <= 1'b1;
    tq.push_back(8'hC1);
    tq.push_back(8'hC1);
    tq.push_back(8'hC4);
    frame(FR_RNR, 1'b0, 1'b0);
    drain();
    chk(irq_cnt, 8'h31);
    give_verdict();
  end
endmodule
